// *** verilog/pga_pkg.sv ***
package pga_pkg;
    // Register offsets on the plain register port.
    localparam logic [7:0] PGA_OFF_PG_CTRL = 8'h17;
    localparam logic [7:0] PGA_OFF_A_SEL = 8'h18;
    localparam logic [7:0] PGA_OFF_A_LATCH = 8'h19;
    localparam logic [7:0] PGA_OFF_B_SEL = 8'h1a;
    localparam logic [7:0] PGA_OFF_B_LATCH = 8'h1b;
    localparam logic [7:0] PGA_OFF_MON_CTRL = 8'h13;
    localparam logic [7:0] PGA_OFF_INT_STAT = 8'h30;
    localparam logic [7:0] PGA_OFF_INT_MASK = 8'h31;
    // Field positions.
    localparam int PGA_BIT_HOLDOFF = 7;
    localparam int PGA_BIT_THERMAL = 6;
    localparam int PGA_BIT_METHOD = 6;
    localparam int PGA_BIT_A_POL = 0;
    localparam int PGA_BIT_A_GATE = 2;
    localparam int PGA_BIT_B_POL = 4;
    localparam int PGA_BIT_B_GATE = 6;
    localparam int PGA_NSRC = 7;
    // Reset values.
    localparam logic [7:0] PGA_RST_SEL = 8'h00;
    localparam logic [7:0] PGA_RST_LATCH = 8'h00;
    localparam logic [7:0] PGA_RST_PG_CTRL = 8'h02;
    localparam logic [1:0] PGA_RST_INT = 2'h0;
    // Rise hold-off time.
    localparam int PGA_CLK_HZ = 40000000;
    localparam int PGA_HOLDOFF_MS = 11;
    localparam int PGA_HOLDOFF_CYC = PGA_CLK_HZ / 1000 * PGA_HOLDOFF_MS;
    localparam int PGA_CNT_W = 20;
    typedef enum logic [1:0] {
        PGA_LOW = 2'b00,
        PGA_WAIT = 2'b01,
        PGA_HIGH = 2'b11
    } pga_state_t;
endpackage

// *** verilog/pga_chan_if.sv ***
`timescale 1ns/1ps
interface pga_chan_if;
    import pga_pkg::*;
    logic good;
    logic holdoff_en;
    logic [19:0] holdoff_cyc;
    logic out_good;
    modport ctrl (output good, output holdoff_en, output holdoff_cyc,
        input out_good);
    modport chan (input good, input holdoff_en, input holdoff_cyc,
        output out_good);
endinterface

// *** verilog/pga_holdoff.sv ***
`timescale 1ns/1ps
module pga_holdoff (
    input wire logic ref_clk,
    input wire logic rst_b,
    pga_chan_if.chan ch
);
    import pga_pkg::*;
    pga_state_t state;
    pga_state_t next_state;
    logic [PGA_CNT_W-1:0] cnt;
    logic [PGA_CNT_W-1:0] next_cnt;

    // Falls pass at once; rises wait for the full count when enabled.
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        unique case (state)
            PGA_LOW: begin
                if (ch.good && ch.holdoff_en) begin
                    next_state = PGA_WAIT;
                    next_cnt = ch.holdoff_cyc - 20'h00001;
                end else if (ch.good) begin
                    next_state = PGA_HIGH;
                end
            end
            PGA_WAIT: begin
                if (!ch.good) begin
                    next_state = PGA_LOW;
                end else if (cnt == '0 || !ch.holdoff_en) begin
                    next_state = PGA_HIGH;
                end else begin
                    next_cnt = cnt - 20'h00001;
                end
            end
            PGA_HIGH: begin
                if (!ch.good) begin
                    next_state = PGA_LOW;
                end
            end
            default: next_state = PGA_LOW;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state <= PGA_LOW;
            cnt <= '0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    assign ch.out_good = (state == PGA_HIGH);
endmodule

// *** verilog/pga_top.sv ***
`timescale 1ns/1ps
module pga_top (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    input wire logic [5:0] src_uv_ok,
    input wire logic [5:0] src_ov_ok,
    input wire logic thermal_warning,
    input wire logic otp_load,
    input wire logic [7:0] otp_a_sel,
    input wire logic [7:0] otp_b_sel,
    input wire logic [7:0] otp_pg_ctrl,
    input wire logic [7:0] otp_mon_ctrl,
    output logic good_out_a,
    output logic good_out_b,
    output logic irq
);
    import pga_pkg::*;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] a_sel, b_sel, pg_ctrl, mon_ctrl;
    logic [7:0] next_a_sel, next_b_sel, next_pg_ctrl, next_mon_ctrl;
    logic [6:0] a_latch, b_latch, next_a_latch, next_b_latch;
    logic [6:0] prev_valid, next_prev_valid;
    logic [1:0] int_stat, int_mask, next_int_stat, next_int_mask;
    logic [7:0] next_rdata;
    logic next_irq, next_good_a, next_good_b;
    logic [6:0] valid;
    logic live_a, live_b, pre_a, pre_b;
    pga_chan_if ch_a ();
    pga_chan_if ch_b ();

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = wr_en && (a == o);
    endfunction

    // ------------------------------------------------------------
    // Source validity and live status
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            valid[i] = src_uv_ok[i] &&
                (!mon_ctrl[PGA_BIT_METHOD] || src_ov_ok[i]);
        end
        valid[6] = !thermal_warning;
        // Unselected sources count as valid, so none selected is good.
        live_a = &(valid | ~a_sel[6:0]);
        live_b = &(valid | ~b_sel[6:0]);
        pre_a = pg_ctrl[PGA_BIT_A_GATE] ? (a_latch == '0) : live_a;
        pre_b = pg_ctrl[PGA_BIT_B_GATE] ? (b_latch == '0) : live_b;
    end

    assign ch_a.good = pre_a;
    assign ch_a.holdoff_en = a_sel[PGA_BIT_HOLDOFF];
    assign ch_a.holdoff_cyc = PGA_HOLDOFF_CYC[19:0];
    assign ch_b.good = pre_b;
    assign ch_b.holdoff_en = b_sel[PGA_BIT_HOLDOFF];
    assign ch_b.holdoff_cyc = PGA_HOLDOFF_CYC[19:0];

    pga_holdoff u_hold_a (.ref_clk(ref_clk), .rst_b(rst_b), .ch(ch_a));
    pga_holdoff u_hold_b (.ref_clk(ref_clk), .rst_b(rst_b), .ch(ch_b));

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic [6:0] fall;
        fall = prev_valid & ~valid;
        next_prev_valid = valid;
        next_a_sel = a_sel;
        next_b_sel = b_sel;
        next_pg_ctrl = pg_ctrl;
        next_mon_ctrl = mon_ctrl;
        if (otp_load) begin
            next_a_sel = {a_sel[7], otp_a_sel[6:0]};
            next_b_sel = {b_sel[7], otp_b_sel[6:0]};
            next_pg_ctrl = otp_pg_ctrl;
            next_mon_ctrl = otp_mon_ctrl;
        end else begin
            if (hit(addr, PGA_OFF_A_SEL)) next_a_sel = wdata;
            if (hit(addr, PGA_OFF_B_SEL)) next_b_sel = wdata;
            if (hit(addr, PGA_OFF_PG_CTRL)) next_pg_ctrl = wdata;
            if (hit(addr, PGA_OFF_MON_CTRL)) next_mon_ctrl = wdata;
        end
        // Clear only where the source is valid; a new fault wins.
        next_a_latch = a_latch;
        next_b_latch = b_latch;
        if (hit(addr, PGA_OFF_A_LATCH)) begin
            next_a_latch = a_latch & ~(wdata[6:0] & valid);
        end
        if (hit(addr, PGA_OFF_B_LATCH)) begin
            next_b_latch = b_latch & ~(wdata[6:0] & valid);
        end
        next_a_latch = next_a_latch | (fall & a_sel[6:0]);
        next_b_latch = next_b_latch | (fall & b_sel[6:0]);
        // Interrupt status: bit 0 output A latch set, bit 1 output B.
        next_int_stat = int_stat;
        if (hit(addr, PGA_OFF_INT_STAT)) begin
            next_int_stat = int_stat & ~wdata[1:0];
        end
        next_int_stat = next_int_stat |
            {|(fall & b_sel[6:0]), |(fall & a_sel[6:0])};
        next_int_mask = int_mask;
        if (hit(addr, PGA_OFF_INT_MASK)) next_int_mask = wdata[1:0];
        next_irq = |(next_int_stat & next_int_mask);
        next_good_a = ch_a.out_good ^ pg_ctrl[PGA_BIT_A_POL];
        next_good_b = ch_b.out_good ^ pg_ctrl[PGA_BIT_B_POL];
        next_rdata = 8'h00;
        if (rd_en) begin
            unique case (addr)
                PGA_OFF_A_SEL: next_rdata = a_sel;
                PGA_OFF_B_SEL: next_rdata = b_sel;
                PGA_OFF_PG_CTRL: next_rdata = pg_ctrl;
                PGA_OFF_MON_CTRL: next_rdata = mon_ctrl;
                PGA_OFF_A_LATCH: next_rdata = {1'b0, a_latch};
                PGA_OFF_B_LATCH: next_rdata = {1'b0, b_latch};
                PGA_OFF_INT_STAT: next_rdata = {6'h00, int_stat};
                PGA_OFF_INT_MASK: next_rdata = {6'h00, int_mask};
                default: next_rdata = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            a_sel <= PGA_RST_SEL;
            b_sel <= PGA_RST_SEL;
            pg_ctrl <= PGA_RST_PG_CTRL;
            mon_ctrl <= PGA_RST_SEL;
            a_latch <= PGA_RST_LATCH[6:0];
            b_latch <= PGA_RST_LATCH[6:0];
            prev_valid <= 7'h7f;
            int_stat <= PGA_RST_INT;
            int_mask <= PGA_RST_INT;
            rdata <= 8'h00;
            irq <= 1'b0;
            good_out_a <= 1'b0;
            good_out_b <= 1'b0;
        end else begin
            a_sel <= next_a_sel;
            b_sel <= next_b_sel;
            pg_ctrl <= next_pg_ctrl;
            mon_ctrl <= next_mon_ctrl;
            a_latch <= next_a_latch;
            b_latch <= next_b_latch;
            prev_valid <= next_prev_valid;
            int_stat <= next_int_stat;
            int_mask <= next_int_mask;
            rdata <= next_rdata;
            irq <= next_irq;
            good_out_a <= next_good_a;
            good_out_b <= next_good_b;
        end
    end
endmodule

// *** dv/pga_top_chk.sv ***
`timescale 1ns/1ps
module pga_top_chk
    import pga_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] rdata,
    input wire logic otp_load,
    input wire logic [7:0] otp_a_sel
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    property p_rd_idle;
        !$past(rd_en) |-> rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
    property p_a_res;
        rd_en && addr == PGA_OFF_A_LATCH |=> rdata[7] == 1'b0;
    endproperty
    a_a_res: assert property (p_a_res) else $error("A latch bit7 set");
    property p_b_res;
        rd_en && addr == PGA_OFF_B_LATCH |=> rdata[7] == 1'b0;
    endproperty
    a_b_res: assert property (p_b_res) else $error("B latch bit7 set");
    property p_a_sel_rw;
        wr_en && !otp_load && addr == PGA_OFF_A_SEL ##1
        rd_en && !otp_load && addr == PGA_OFF_A_SEL
        |=> rdata == $past(wdata, 2);
    endproperty
    a_a_sel_rw: assert property (p_a_sel_rw) else $error("A sel rw");
    property p_b_sel_rw;
        wr_en && !otp_load && addr == PGA_OFF_B_SEL ##1
        rd_en && !otp_load && addr == PGA_OFF_B_SEL
        |=> rdata == $past(wdata, 2);
    endproperty
    a_b_sel_rw: assert property (p_b_sel_rw) else $error("B sel rw");
    property p_ctrl_rw;
        wr_en && !otp_load && addr == PGA_OFF_PG_CTRL ##1
        rd_en && !otp_load && addr == PGA_OFF_PG_CTRL
        |=> rdata == $past(wdata, 2);
    endproperty
    a_ctrl_rw: assert property (p_ctrl_rw) else $error("ctrl rw");
    property p_mon_rw;
        wr_en && !otp_load && addr == PGA_OFF_MON_CTRL ##1
        rd_en && !otp_load && addr == PGA_OFF_MON_CTRL
        |=> rdata[6] == $past(wdata[6], 2);
    endproperty
    a_mon_rw: assert property (p_mon_rw) else $error("method rw");
    property p_otp;
        otp_load ##1 rd_en && addr == PGA_OFF_A_SEL
        |=> rdata[6:0] == $past(otp_a_sel[6:0], 2);
    endproperty
    a_otp: assert property (p_otp) else $error("otp load");
endmodule
bind pga_top pga_top_chk i_pga_top_chk(.ref_clk(ref_clk), .rst_b(rst_b),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .otp_load(otp_load), .otp_a_sel(otp_a_sel));

// *** dv/pga_supply_model.sv ***
`timescale 1ns/1ps
module pga_supply_model (
    input wire logic ref_clk,
    input wire logic [6:0] fail,
    input wire logic [5:0] ov_fail,
    output logic [5:0] src_uv_ok,
    output logic [5:0] src_ov_ok,
    output logic thermal_warning
);
    always_ff @(posedge ref_clk) begin
        src_uv_ok <= ~fail[5:0];
        src_ov_ok <= ~ov_fail;
        thermal_warning <= fail[6];
    end
endmodule

// *** dv/pga_tb_top.sv ***
`timescale 1ns/1ps
module pga_tb_top;
    import pga_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic otp_load = 1'b0;
    logic [6:0] fail = 7'h00;
    logic [5:0] ov_fail = 6'h00;
    logic [7:0] rdata;
    logic [5:0] src_uv_ok;
    logic [5:0] src_ov_ok;
    logic thermal_warning;
    logic good_out_a;
    logic good_out_b;
    logic irq;
    logic [7:0] zero_regs [6] = '{PGA_OFF_A_SEL, PGA_OFF_A_LATCH,
        PGA_OFF_B_SEL, PGA_OFF_B_LATCH, PGA_OFF_MON_CTRL, 8'h00};
    int fails = 0;
    int n_tests = 0;
    always #12.5 ref_clk = ~ref_clk;
    pga_supply_model i_pga_supply_model(.ref_clk(ref_clk), .fail(fail),
        .ov_fail(ov_fail), .src_uv_ok(src_uv_ok), .src_ov_ok(src_ov_ok),
        .thermal_warning(thermal_warning));
    pga_top i_pga_top(.ref_clk(ref_clk), .rst_b(rst_b), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .src_uv_ok(src_uv_ok), .src_ov_ok(src_ov_ok),
        .thermal_warning(thermal_warning), .otp_load(otp_load),
        .otp_a_sel(8'h05), .otp_b_sel(8'h0a), .otp_pg_ctrl(8'h02),
        .otp_mon_ctrl(8'h00), .good_out_a(good_out_a),
        .good_out_b(good_out_b), .irq(irq));
    task automatic chk(input string name, input logic [7:0] exp,
            input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        rd_en <= 1'b0;
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        wr_en <= 1'b0;
        addr <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), exp, rdata);
    endtask
    task automatic idle(input int n);
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Register, latch, output and hold-off sequences.
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge ref_clk);
        rst_b <= 1'b1;
        idle(4);
        rd(PGA_OFF_PG_CTRL, PGA_RST_PG_CTRL);
        for (int i = 0; i < 6; i++) rd(zero_regs[i], 8'h00);
        chk("good_out_a", 8'h01, {7'h00, good_out_a});
        chk("good_out_b", 8'h01, {7'h00, good_out_b});
        wr(PGA_OFF_A_SEL, 8'h01);
        rd(PGA_OFF_A_SEL, 8'h01);
        fail <= 7'h01;
        idle(6);
        chk("good_out_a", 8'h00, {7'h00, good_out_a});
        chk("good_out_b", 8'h01, {7'h00, good_out_b});
        rd(PGA_OFF_A_LATCH, 8'h01);
        rd(PGA_OFF_B_LATCH, 8'h00);
        wr(PGA_OFF_A_LATCH, 8'h01);
        rd(PGA_OFF_A_LATCH, 8'h01);
        rd(PGA_OFF_INT_STAT, 8'h01);
        chk("irq", 8'h00, {7'h00, irq});
        wr(PGA_OFF_INT_MASK, 8'h03);
        idle(2);
        chk("irq", 8'h01, {7'h00, irq});
        wr(PGA_OFF_INT_STAT, 8'h01);
        rd(PGA_OFF_INT_STAT, 8'h00);
        fail <= 7'h00;
        idle(6);
        chk("good_out_a", 8'h01, {7'h00, good_out_a});
        wr(PGA_OFF_PG_CTRL, 8'h06);
        rd(PGA_OFF_PG_CTRL, 8'h06);
        idle(4);
        chk("good_out_a", 8'h00, {7'h00, good_out_a});
        wr(PGA_OFF_A_LATCH, 8'h01);
        rd(PGA_OFF_A_LATCH, 8'h00);
        idle(4);
        chk("good_out_a", 8'h01, {7'h00, good_out_a});
        wr(PGA_OFF_PG_CTRL, 8'h03);
        idle(4);
        chk("good_out_a", 8'h00, {7'h00, good_out_a});
        wr(PGA_OFF_PG_CTRL, 8'h02);
        wr(PGA_OFF_B_SEL, 8'h40);
        rd(PGA_OFF_B_SEL, 8'h40);
        fail <= 7'h40;
        idle(6);
        chk("good_out_b", 8'h00, {7'h00, good_out_b});
        rd(PGA_OFF_B_LATCH, 8'h40);
        chk("irq", 8'h01, {7'h00, irq});
        wr(PGA_OFF_B_LATCH, 8'h40);
        rd(PGA_OFF_B_LATCH, 8'h40);
        fail <= 7'h00;
        idle(4);
        wr(PGA_OFF_B_LATCH, 8'h40);
        rd(PGA_OFF_B_LATCH, 8'h00);
        ov_fail <= 6'h01;
        idle(6);
        chk("good_out_a", 8'h01, {7'h00, good_out_a});
        wr(PGA_OFF_MON_CTRL, 8'h40);
        rd(PGA_OFF_MON_CTRL, 8'h40);
        idle(4);
        chk("good_out_a", 8'h00, {7'h00, good_out_a});
        ov_fail <= 6'h00;
        wr(PGA_OFF_A_SEL, 8'h81);
        wr(PGA_OFF_B_SEL, 8'h81);
        fail <= 7'h01;
        idle(6);
        fail <= 7'h00;
        idle(50);
        chk("good_out_a", 8'h00, {7'h00, good_out_a});
        chk("good_out_b", 8'h00, {7'h00, good_out_b});
        otp_load <= 1'b1;
        @(posedge ref_clk);
        otp_load <= 1'b0;
        rd(PGA_OFF_A_SEL, 8'h85);
        rd(PGA_OFF_B_SEL, 8'h8a);
        results();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        results();
    end
endmodule
